// *** rtl/etee_pkg.sv ***
// Constants shared by the emulation trap entry and exit logic
package etee_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int VEC_N = 10;
  localparam int VEC_IDX_W = 4;
  localparam int RAM_N = 16;
  // Avalon byte offsets
  localparam logic [7:0] RAM_BASE = 8'h00;
  localparam logic [7:0] RAM_LAST = 8'h3c;
  localparam logic [7:0] VEC_BASE = 8'h40;
  localparam logic [7:0] VEC_LAST = 8'h64;
  localparam logic [7:0] CTRL_OFS = 8'h80;
  localparam logic [7:0] STAT_OFS = 8'h84;
  localparam logic [7:0] ERR_OFS = 8'h88;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_BASELINE_BIT = 0;
  localparam int ERR_ILLEGAL_OPCODE_FLAG_BIT = 0;
  // Workspace register numbers in emulation RAM
  localparam logic [3:0] WR_CONTEXT = 4'h3;
  localparam logic [3:0] WR_OPCODE = 4'h5;
  localparam logic [3:0] WR_OLD_WP = 4'hd;
  localparam logic [3:0] WR_OLD_PC = 4'he;
  localparam logic [3:0] WR_OLD_ST = 4'hf;
  // Bit positions, MSB-first numbering mapped onto [15:0]
  localparam int ST_AF_ARITH = 11;
  localparam int ST_AF_ENABLE = 5;
  localparam int ST_PRIV_BIT = 8;
  localparam int ST_XOP_TRAP_BIT = 4;
  localparam int OPC_GROUP_LSB = 8;
  localparam logic [15:0] CTX_KEEP_MASK = 16'h0033;
  localparam int CTX_LD_FLAGS_LSB = 13;
  // Vector table
  localparam logic [15:0] VEC_TABLE_BASE = 16'h0800;
  localparam logic [3:0] VEC_IDX_TWO_WORD = 4'h8;
  localparam logic [3:0] VEC_IDX_XOP = 4'h9;
  localparam logic [15:0] EMU_WP_ENTRY = 16'h0000;
  // Return opcodes
  localparam logic [15:0] OPC_RET_STD = 16'h0380;
  localparam logic [15:0] OPC_RET_INNER = 16'h0381;
  localparam logic [15:0] OPC_RET_ILLEGAL = 16'h0382;
  localparam logic [15:0] OPC_RET_NOSAMPLE = 16'h0384;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_APP_TEST,
    ST_VEC_READ,
    ST_SAVE,
    ST_IN_STORE,
    ST_EXIT
  } etee_state_e;
endpackage

// *** rtl/etee_trap_unit.sv ***
// Emulation trap entry and exit controller with Avalon-MM register slave
//
// What this block does
// (RULE_01) Trap opcode in main code tests attached-processor pin; enter store only when none ready.
// (RULE_02) Trap opcodes: undefined base opcodes, and extended operations while status bit 11 set.
// (RULE_03) Routine start address comes from a ten-word entry table at emulation ROM start.
// (RULE_04) Undefined single-word opcodes pick one of eight entries by opcode bits 5..7.
// (RULE_05) Illegal second word uses ninth entry; trapped extended operation uses tenth entry.
// (RULE_06) After vector read, workspace pointer becomes zero and program counter the vector.
// (RULE_07) Old workspace pointer, counter and status saved into workspace registers 13, 14, 15.
// (RULE_08) Saved counter points after trapping opcode, or after first word of two-word one.
// (RULE_09) Trapping first word is copied whole into workspace register 5.
// (RULE_10) Trapping second word goes to register 5; first-word bits 10,11,14,15 into register 3.
// (RULE_11) Register 3 bits 0..2 take the current long-distance source/destination flags.
// (RULE_12) Standard return reloads pointer, counter, status from 13..15 then samples interrupts.
// (RULE_13) Alternate return reloads the same but skips interrupt sampling before next instruction.
// (RULE_14) Illegal return sets the illegal-opcode flag then performs the normal reload.
// (RULE_15) Set illegal-opcode flag forces level-2 trap in main memory, unmaskable.
// (RULE_16) Only the three special returns exit; the inner return variant stays in the store.
// (RULE_17) Entry context switch leaves the status register untouched.
// (RULE_18) Store code may write status and do privileged work regardless of bit 7.
// (RULE_19) Load-status in the store drives the status-update bus code.
// (RULE_20) Status bits 4 and 10 raise no fault inside; saved ones raise it on exit.
// (RULE_21) All interrupts but reset blocked in the store; pending ones stay visible.
// (RULE_22) Disabled-store mode: trap raises level-2 and sets the flag without pin test.
// (RULE_23) Attached processor ready: skip store entry, leave opcode to that processor.
`timescale 1ns/1ps
`default_nettype none
module etee_trap_unit
  import etee_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [etee_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [etee_pkg::DATA_W-1:0] avs_writedata,
  output logic [etee_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic attached_processor_present_n,
  input wire logic trap_undefined,
  input wire logic trap_second_illegal,
  input wire logic trap_extended_operation,
  input wire logic [etee_pkg::WORD_W-1:0] first_word,
  input wire logic [etee_pkg::WORD_W-1:0] second_word,
  input wire logic [etee_pkg::WORD_W-1:0] cur_wp,
  input wire logic [etee_pkg::WORD_W-1:0] next_pc,
  input wire logic [etee_pkg::WORD_W-1:0] cur_st,
  input wire logic [2:0] long_distance_flags,
  input wire logic ret_exec,
  input wire logic [etee_pkg::WORD_W-1:0] ret_opcode,
  input wire logic load_status_instruction,
  input wire logic irq_pending,
  input wire logic illegal_opcode_clear,
  output logic ctx_load_r,
  output logic [etee_pkg::WORD_W-1:0] ctx_wp_r,
  output logic [etee_pkg::WORD_W-1:0] ctx_pc_r,
  output logic [etee_pkg::WORD_W-1:0] ctx_st_r,
  output logic ctx_st_valid_r,
  output logic in_store_r,
  output logic irq_block_r,
  output logic priv_override_r,
  output logic irq_pending_seen_r,
  output logic irq_sample_r,
  output logic inner_return_r,
  output logic handoff_r,
  output logic status_bus_code_r,
  output logic illegal_opcode_flag_r,
  output logic level2_trap_r,
  output logic arithmetic_fault_flag_r
);
  import etee_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  etee_state_e state_r;
  logic [1:0] app_sync_r;
  logic [WORD_W-1:0] ram_r [RAM_N];
  logic [31:0] ctrl_r;
  logic two_word_r;
  logic xop_r;
  logic [WORD_W-1:0] word1_r;
  logic [WORD_W-1:0] word2_r;
  logic [WORD_W-1:0] wp_r;
  logic [WORD_W-1:0] pc_r;
  logic [WORD_W-1:0] st_r;
  logic [2:0] ldf_r;
  logic [WORD_W-1:0] exit_op_r;
  logic [WORD_W-1:0] vector;
  logic [WORD_W-1:0] vec_rdata;
  logic mid_trap;
  logic is_exit;
  logic bus_req;
  logic bus_done;
  logic bus_wr;
  logic hw_busy;
  logic [WORD_W-1:0] wr3_value;

  function automatic logic in_ram(input logic [ADDR_W-1:0] a);
    in_ram = (a >= RAM_BASE) && (a <= RAM_LAST);
  endfunction

  function automatic logic in_vec(input logic [ADDR_W-1:0] a);
    in_vec = (a >= VEC_BASE) && (a <= VEC_LAST);
  endfunction

  // Trap classification; extended operation only traps with its status bit set
  assign mid_trap = trap_undefined || trap_second_illegal ||
                    (trap_extended_operation && cur_st[ST_XOP_TRAP_BIT]); // RULE_02
  assign is_exit = (ret_opcode == OPC_RET_STD) || (ret_opcode == OPC_RET_ILLEGAL) ||
                   (ret_opcode == OPC_RET_NOSAMPLE); // RULE_16
  // A bus write taken during vector read would land in the save cycle and be lost
  assign hw_busy = (state_r == ST_VEC_READ) || (state_r == ST_SAVE) || (state_r == ST_EXIT);
  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !avs_waitrequest;
  assign bus_wr = avs_write && bus_done;
  assign wr3_value = (word1_r & CTX_KEEP_MASK) | {ldf_r, 13'h0000}; // RULE_10 RULE_11

  etee_vector_table u_vectors (
    .clock(clock),
    .sys_rst(sys_rst),
    .bus_wr(bus_wr && in_vec(avs_address)),
    .bus_idx(4'((avs_address - VEC_BASE) >> 2)),
    .bus_wdata(avs_writedata[WORD_W-1:0]),
    .bus_rdata(vec_rdata),
    .sel_two_word(two_word_r),
    .sel_xop(xop_r),
    .opcode(word1_r),
    .vector_r(vector)
  );

  // Attached-processor pin synchroniser
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      app_sync_r <= 2'b11;
    else
      app_sync_r <= {app_sync_r[0], attached_processor_present_n};
  end

  // Trap context capture
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      two_word_r <= 1'b0;
      xop_r <= 1'b0;
      word1_r <= '0;
      word2_r <= '0;
      wp_r <= '0;
      pc_r <= '0;
      st_r <= '0;
      ldf_r <= '0;
      exit_op_r <= '0;
    end
    else if (state_r == ST_IDLE && mid_trap)
    begin
      two_word_r <= trap_second_illegal;
      xop_r <= !trap_undefined && !trap_second_illegal;
      word1_r <= first_word;
      word2_r <= second_word;
      wp_r <= cur_wp;
      pc_r <= next_pc; // RULE_08
      st_r <= cur_st;
      ldf_r <= long_distance_flags;
    end
    else if (state_r == ST_IN_STORE && ret_exec)
      exit_op_r <= ret_opcode;
  end

  // Sequencer
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
          if (mid_trap && !ctrl_r[CTRL_BASELINE_BIT])
            state_r <= ST_APP_TEST;
        ST_APP_TEST:
          if (app_sync_r[1])
            state_r <= ST_VEC_READ; // RULE_01
          else
            state_r <= ST_IDLE; // RULE_23
        ST_VEC_READ:
          state_r <= ST_SAVE;
        ST_SAVE:
          state_r <= ST_IN_STORE;
        ST_IN_STORE:
          if (ret_exec && is_exit)
            state_r <= ST_EXIT;
        ST_EXIT:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Emulation RAM workspace: hardware save, or bus access when hardware is quiet
  genvar r;
  generate
    for (r = 0; r < RAM_N; r++)
    begin : g_ram
      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
          ram_r[r] <= '0;
        else if (state_r == ST_SAVE)
        begin
          if (4'(r) == WR_OLD_WP)
            ram_r[r] <= wp_r; // RULE_07
          else if (4'(r) == WR_OLD_PC)
            ram_r[r] <= pc_r; // RULE_07
          else if (4'(r) == WR_OLD_ST)
            ram_r[r] <= st_r; // RULE_07
          else if (4'(r) == WR_OPCODE)
            ram_r[r] <= two_word_r ? word2_r : word1_r; // RULE_09 RULE_10
          else if (4'(r) == WR_CONTEXT)
            ram_r[r] <= wr3_value; // RULE_10 RULE_11
        end
        else if (bus_wr && in_ram(avs_address) && avs_address[5:2] == 4'(r))
        begin
          if (avs_byteenable[0])
            ram_r[r][7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1])
            ram_r[r][15:8] <= avs_writedata[15:8];
        end
      end
    end
  endgenerate

  // Context loads toward the core
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctx_load_r <= 1'b0;
      ctx_st_valid_r <= 1'b0;
      ctx_wp_r <= '0;
      ctx_pc_r <= '0;
      ctx_st_r <= '0;
    end
    else if (state_r == ST_SAVE)
    begin
      ctx_load_r <= 1'b1;
      ctx_st_valid_r <= 1'b0; // RULE_17
      ctx_wp_r <= EMU_WP_ENTRY; // RULE_06
      ctx_pc_r <= vector; // RULE_06
    end
    else if (state_r == ST_EXIT)
    begin
      ctx_load_r <= 1'b1;
      ctx_st_valid_r <= 1'b1;
      ctx_wp_r <= ram_r[WR_OLD_WP]; // RULE_12
      ctx_pc_r <= ram_r[WR_OLD_PC]; // RULE_12
      ctx_st_r <= ram_r[WR_OLD_ST]; // RULE_12
    end
    else
    begin
      ctx_load_r <= 1'b0;
      ctx_st_valid_r <= 1'b0;
    end
  end

  // Store residency: interrupt block and super-privilege
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      in_store_r <= 1'b0;
      irq_block_r <= 1'b0;
      priv_override_r <= 1'b0;
      irq_pending_seen_r <= 1'b0;
    end
    else
    begin
      in_store_r <= (state_r == ST_SAVE) || (state_r == ST_IN_STORE);
      irq_block_r <= (state_r == ST_SAVE) || (state_r == ST_IN_STORE); // RULE_21
      priv_override_r <= (state_r == ST_SAVE) || (state_r == ST_IN_STORE); // RULE_18
      irq_pending_seen_r <= irq_pending; // RULE_21
    end
  end

  // Event pulses
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_sample_r <= 1'b0;
      inner_return_r <= 1'b0;
      handoff_r <= 1'b0;
      status_bus_code_r <= 1'b0;
      arithmetic_fault_flag_r <= 1'b0;
    end
    else
    begin
      irq_sample_r <= (state_r == ST_EXIT) && (exit_op_r != OPC_RET_NOSAMPLE); // RULE_12 RULE_13
      inner_return_r <= (state_r == ST_IN_STORE) && ret_exec &&
                        (ret_opcode == OPC_RET_INNER); // RULE_16
      handoff_r <= (state_r == ST_APP_TEST) && !app_sync_r[1]; // RULE_23
      status_bus_code_r <= (state_r == ST_IN_STORE) && load_status_instruction; // RULE_19
      arithmetic_fault_flag_r <= (state_r == ST_EXIT) && ram_r[WR_OLD_ST][ST_AF_ARITH] &&
                                 ram_r[WR_OLD_ST][ST_AF_ENABLE]; // RULE_20
    end
  end

  // Illegal-opcode flag: set wins over clear
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      illegal_opcode_flag_r <= 1'b0;
    else if ((state_r == ST_IN_STORE && ret_exec && ret_opcode == OPC_RET_ILLEGAL) ||
             (state_r == ST_IDLE && mid_trap && ctrl_r[CTRL_BASELINE_BIT])) // RULE_14 RULE_22
      illegal_opcode_flag_r <= 1'b1;
    else if (illegal_opcode_clear ||
             (bus_wr && avs_address == ERR_OFS && avs_byteenable[0] &&
              avs_writedata[ERR_ILLEGAL_OPCODE_FLAG_BIT]))
      illegal_opcode_flag_r <= 1'b0;
  end

  // Level-2 trap request, unmaskable, only outside the store
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      level2_trap_r <= 1'b0;
    else
      level2_trap_r <= illegal_opcode_flag_r && (state_r == ST_IDLE); // RULE_15 RULE_22
  end

  // Control register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_r <= CTRL_RESET;
    else if (bus_wr && avs_address == CTRL_OFS && avs_byteenable[0])
      ctrl_r[CTRL_BASELINE_BIT] <= avs_writedata[CTRL_BASELINE_BIT];
  end

  // Avalon slave: one wait cycle per access, held longer while hardware owns the RAM
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else if (bus_req && avs_waitrequest && !hw_busy)
    begin
      avs_waitrequest <= 1'b0;
      if (in_ram(avs_address))
        avs_readdata <= {16'h0000, ram_r[avs_address[5:2]]};
      else if (in_vec(avs_address))
        avs_readdata <= {16'h0000, vec_rdata};
      else if (avs_address == CTRL_OFS)
        avs_readdata <= ctrl_r;
      else if (avs_address == STAT_OFS)
        avs_readdata <= {28'h000_0000, app_sync_r[1], in_store_r, 2'b00} |
                        {29'h0000_0000, 3'(state_r)};
      else if (avs_address == ERR_OFS)
        avs_readdata <= {31'h0000_0000, illegal_opcode_flag_r};
      else
        avs_readdata <= '0;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  entry_wp_zero_a: assert property ((state_r == ST_SAVE) |=> ctx_load_r && ctx_wp_r == 16'h0000
                                   && ctx_pc_r == $past(vector)) // RULE_06
    else $error("entry did not load zero workspace and vector");
  save_regs_a: assert property ((state_r == ST_SAVE) |=> ram_r[WR_OLD_PC] == $past(pc_r)
                                && ram_r[WR_OLD_WP] == $past(wp_r)
                                && ram_r[WR_OLD_ST] == $past(st_r)) // RULE_07
    else $error("old context not saved");
  entry_st_keep_a: assert property ((state_r == ST_SAVE) |=> !ctx_st_valid_r) // RULE_17
    else $error("status changed on entry");
  baseline_illegal_opcode_flag_a: assert property ((state_r == ST_IDLE && mid_trap && ctrl_r[CTRL_BASELINE_BIT]
                                     && !illegal_opcode_flag_r) |=> illegal_opcode_flag_r
                                     && state_r == ST_IDLE ##1 level2_trap_r) // RULE_22
    else $error("disabled store trap did not raise level 2");
  app_skip_a: assert property ((state_r == ST_APP_TEST && !app_sync_r[1]) |=> handoff_r
                               && state_r == ST_IDLE ##1 !in_store_r) // RULE_23
    else $error("attached processor ready but store entered");
  nosample_exit_a: assert property ((state_r == ST_IN_STORE && ret_exec
                                    && ret_opcode == OPC_RET_NOSAMPLE) |=> ##1 !irq_sample_r
                                    && ctx_load_r) // RULE_13
    else $error("alternate return sampled interrupts");
  std_exit_a: assert property ((state_r == ST_IN_STORE && ret_exec && ret_opcode == OPC_RET_STD)
                               |=> ##1 irq_sample_r && ctx_st_valid_r
                               && ctx_pc_r == $past(ram_r[WR_OLD_PC])) // RULE_12
    else $error("standard return did not reload and sample");
  inner_stay_a: assert property ((state_r == ST_IN_STORE && ret_exec
                                 && ret_opcode == OPC_RET_INNER) |=> state_r == ST_IN_STORE
                                 && inner_return_r ##1 in_store_r) // RULE_16
    else $error("inner return left the store");
  illegal_opcode_flag_exit_a: assert property ((state_r == ST_IN_STORE && ret_exec
                                 && ret_opcode == OPC_RET_ILLEGAL) |=> illegal_opcode_flag_r
                                 ##1 ctx_load_r) // RULE_14
    else $error("illegal return did not set flag");
  irq_block_a: assert property ((state_r == ST_IN_STORE) |-> irq_block_r
                                && priv_override_r) // RULE_21
    else $error("interrupts not blocked in store");
  first_entry_a: assert property ((state_r == ST_APP_TEST && app_sync_r[1]) |=> ##2 in_store_r
                                  && ctx_load_r) // RULE_01
    else $error("store not entered when no attached processor");
endmodule
`default_nettype wire

// *** rtl/etee_vector_table.sv ***
// Ten-word entry vector table with bus write port and group select
`timescale 1ns/1ps
`default_nettype none
module etee_vector_table
  import etee_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic bus_wr,
  input wire logic [VEC_IDX_W-1:0] bus_idx,
  input wire logic [WORD_W-1:0] bus_wdata,
  output logic [WORD_W-1:0] bus_rdata,
  input wire logic sel_two_word,
  input wire logic sel_xop,
  input wire logic [WORD_W-1:0] opcode,
  output logic [WORD_W-1:0] vector_r
);
  logic [WORD_W-1:0] table_r [VEC_N];

  function automatic logic [VEC_IDX_W-1:0] group_index(input logic two_w, input logic extended_operation,
                                                        input logic [WORD_W-1:0] opc);
    if (extended_operation)
      group_index = VEC_IDX_XOP;
    else if (two_w)
      group_index = VEC_IDX_TWO_WORD;
    else
      group_index = {1'b0, opc[OPC_GROUP_LSB+2:OPC_GROUP_LSB]};
  endfunction

  genvar g;
  generate
    for (g = 0; g < VEC_N; g++)
    begin : g_entry
      always_ff @(posedge clock or posedge sys_rst)
      begin
        if (sys_rst)
          table_r[g] <= VEC_TABLE_BASE;
        else if (bus_wr && bus_idx == VEC_IDX_W'(g))
          table_r[g] <= bus_wdata;
      end
    end
  endgenerate

  assign bus_rdata = (bus_idx < VEC_IDX_W'(VEC_N)) ? table_r[bus_idx] : '0;

  // Registered vector fetch, one cycle after selection
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      vector_r <= '0;
    else
      vector_r <= table_r[group_index(sel_two_word, sel_xop, opcode)]; // RULE_03 RULE_04 RULE_05
  end
endmodule
`default_nettype wire

// *** verif/etee_copro_model.sv ***
// Attached coprocessor that shows readiness and takes handed-off opcodes
`timescale 1ns/1ps
`default_nettype none
module etee_copro_model #(
  parameter int READY_DELAY = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic want_ready,
  input wire logic handoff,
  output logic attached_processor_present_n,
  output logic [7:0] taken_cnt
);
  int wait_r;
  // Readiness shows only after a warm-up; a slow partner takes a larger delay
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      wait_r <= 0;
      attached_processor_present_n <= 1'b1;
    end
    else
    begin
      wait_r <= want_ready ? wait_r + 1 : 0;
      attached_processor_present_n <= !(want_ready && wait_r >= READY_DELAY);
    end
  // An opcode counts as taken only while readiness is shown
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      taken_cnt <= 8'h00;
    else if (handoff && !attached_processor_present_n)
      taken_cnt <= taken_cnt + 8'h01;
endmodule
`default_nettype wire

// *** verif/test_etee_trap_unit.sv ***
// Bench for the emulation trap entry and exit controller
`timescale 1ns/1ps
`default_nettype none
module test_etee_trap_unit;
  import etee_pkg::*;
  logic clock = 0, sys_rst = 1, avs_read = 0, avs_write = 0, want = 0, flt = 0;
  logic [7:0] avs_address = 0, taken;
  logic [3:0] avs_byteenable = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic avs_waitrequest, app_n, tu = 0, t2 = 0, tx = 0, ret_exec = 0, lsi = 0, irq = 0, clr = 0;
  logic [15:0] fw = 0, sw = 0, wp = 16'h3c20, pc = 16'h4a02, st = 0, ret_opcode = 0;
  logic [2:0] ldf = 3'h5;
  logic cl, sv, ins, blk, prv, seen, smp, inr, ho, sbc, ill, l2, af;
  logic [15:0] cwp, cpc, cst;
  int errors = 0, checks = 0;
  always #50 clock = ~clock;
  etee_trap_unit u_etee_trap_unit (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .attached_processor_present_n(app_n), .trap_undefined(tu), .trap_second_illegal(t2),
    .trap_extended_operation(tx), .first_word(fw), .second_word(sw), .cur_wp(wp), .next_pc(pc),
    .cur_st(st), .long_distance_flags(ldf), .ret_exec(ret_exec), .ret_opcode(ret_opcode),
    .load_status_instruction(lsi), .irq_pending(irq), .illegal_opcode_clear(clr),
    .ctx_load_r(cl), .ctx_wp_r(cwp), .ctx_pc_r(cpc), .ctx_st_r(cst), .ctx_st_valid_r(sv),
    .in_store_r(ins), .irq_block_r(blk), .priv_override_r(prv), .irq_pending_seen_r(seen),
    .irq_sample_r(smp), .inner_return_r(inr), .handoff_r(ho), .status_bus_code_r(sbc),
    .illegal_opcode_flag_r(ill), .level2_trap_r(l2), .arithmetic_fault_flag_r(af));
  etee_copro_model u_etee_copro_model (.clock(clock), .sys_rst(sys_rst), .want_ready(want),
    .handoff(ho), .attached_processor_present_n(app_n), .taken_cnt(taken));
  task end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [47:0] g, input logic [47:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Fault pulses are collected on every edge so no pulse slips between checks
  task tick;
    @(posedge clock);
    flt = flt | af;
  endtask
  task wait_on(input int k);
    int n;
    n = 0;
    do
    begin
      tick;
      n++;
    end
    while ((k == 0 ? cl : k == 1 ? ho : k == 2 ? l2 : k == 3 ? inr : !avs_waitrequest) !== 1'b1
      && n < 30);
    if (n >= 30)
    begin
      errors++;
      $display("FAIL %0t: no response", $time);
      end_of_test;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    tick;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= w;
    avs_read <= !w;
    wait_on(4);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [15:0] vec(input int i);
    return 16'h0900 + 16'(i * 16);
  endfunction
  task enter(input logic [2:0] k, input logic [15:0] f, input logic [15:0] s,
    input logic [15:0] t, input logic [15:0] v);
    flt = 0;
    tick;
    {tx, t2, tu} <= k;
    fw <= f;
    sw <= s;
    st <= t;
    tick;
    {tx, t2, tu} <= 3'h0;
    wait_on(0);
    chk({cwp, cpc}, {EMU_WP_ENTRY, v});
    chk({ins, sv}, 2'h2);
    bus(0, 8'h14, 0);
    chk(q, k[1] ? s : f);
    bus(0, 8'h0c, 0);
    chk(q, {ldf, 13'h0000} | (f & CTX_KEEP_MASK));
    bus(0, 8'h34, 0);
    chk(q, wp);
    bus(0, 8'h38, 0);
    chk(q, pc);
    bus(0, 8'h3c, 0);
    chk(q, t);
    chk({blk, prv, seen, flt}, 4'he);
  endtask
  task leave(input logic [15:0] op, input logic [15:0] s, input logic f);
    flt = 0;
    tick;
    ret_exec <= 1'b1;
    ret_opcode <= op;
    tick;
    ret_exec <= 1'b0;
    wait_on(0);
    chk({cwp, cpc, cst}, {wp, pc, s});
    chk({sv, ins}, 2'h2);
    chk(smp, op != OPC_RET_NOSAMPLE);
    tick;
    chk(flt, f);
  endtask
  task t_regs;
    bus(0, VEC_BASE, 0);
    chk(q, VEC_TABLE_BASE);
    bus(1, 8'hfc, 32'hffff_ffff);
    bus(0, 8'hfc, 0);
    chk(q, 0);
    for (int i = 0; i < 10; i++)
      bus(1, VEC_BASE + 8'(i * 4), {16'h0000, vec(i)});
    bus(0, VEC_LAST, 0);
    chk(q, vec(9));
  endtask
  task t_groups;
    for (int g = 0; g < 8; g++)
    begin
      enter(3'h1, {5'h00, 3'(g), 8'hf3}, 16'h0000, 16'h00c0, vec(g));
      leave(g[0] ? OPC_RET_NOSAMPLE : OPC_RET_STD, 16'h00c0, 1'b0);
    end
  endtask
  task t_two;
    enter(3'h2, 16'h0c31, 16'habcd, 16'h0000, vec(8));
    tick;
    ret_exec <= 1'b1;
    ret_opcode <= OPC_RET_INNER;
    tick;
    ret_exec <= 1'b0;
    wait_on(3);
    tick;
    chk({ins, cl}, 2'h2);
    lsi <= 1'b1;
    tick;
    lsi <= 1'b0;
    tick;
    chk(sbc, 1'b1);
    bus(1, 8'h3c, 32'h0000_0820);
    leave(OPC_RET_STD, 16'h0820, 1'b1);
  endtask
  task t_xop;
    tick;
    tx <= 1'b1;
    st <= 16'h0000;
    tick;
    tx <= 1'b0;
    repeat (8)
    begin
      tick;
      chk(cl | ho | ill, 1'b0);
    end
    enter(3'h4, 16'h2c40, 16'h0000, 16'h0830, vec(9));
    leave(OPC_RET_ILLEGAL, 16'h0830, 1'b1);
    wait_on(2);
    chk(ill, 1'b1);
    bus(1, ERR_OFS, 32'h0000_0001);
    bus(0, ERR_OFS, 0);
    chk(q, 0);
  endtask
  task t_handoff;
    want <= 1'b1;
    repeat (8) tick;
    tu <= 1'b1;
    fw <= 16'h0123;
    tick;
    tu <= 1'b0;
    wait_on(1);
    tick;
    chk({ins, taken}, {1'b0, 8'h01});
  endtask
  task t_base;
    bus(1, CTRL_OFS, 32'h0000_0001);
    tick;
    tu <= 1'b1;
    tick;
    tu <= 1'b0;
    wait_on(2);
    chk({ill, ins, ho}, 3'h4);
    clr <= 1'b1;
    tick;
    clr <= 1'b0;
    repeat (3) tick;
    chk({ill, l2}, 2'h0);
    want <= 1'b0;
    bus(1, CTRL_OFS, 0);
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    irq <= 1'b1;
    t_regs;
    t_groups;
    t_two;
    t_xop;
    t_handoff;
    t_base;
    end_of_test;
  end
endmodule
`default_nettype wire
